// ### verilog/svrwd_pkg.sv
// constants shared by the supervisor, reset stretch and watchdog logic
// assumes a single 25 MHz clock and a synchronous active-high reset
// How it works
// - reset output goes low whenever supply is low or manual reset is held low.
// - after supply recovers, reset stays low for one 200 ms stretch period.
// - after manual reset returns high, reset stays low for the full stretch period.
// - manual reset has no internal pull-up; an undriven input floats and is not read as high.
// - any rising or falling edge on the kick input restarts the watchdog count.
// - a kick input stuck at one level past the watchdog period drives the expired output low.
// - with the disable input high the watchdog is off and its output stays high while supply is valid.
// - while supply is low the expired output is held low until the supply is valid.
// - a watchdog timeout never asserts reset by itself, only through external wiring.
// - an active-high reset output is always the complement of the active-low one.
// - power-fail warning follows the comparator alone, independent of reset and watchdog.
// - the watchdog period is nominally 1.6 s, within 1.0 to 2.25 s.
package svrwd_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned RST_STRETCH_MS = 200;
  localparam int unsigned WD_PERIOD_MS   = 1600;
  localparam int unsigned RST_STRETCH_CYC = (CLK_HZ / 1000) * RST_STRETCH_MS;
  localparam int unsigned WD_PERIOD_CYC   = (CLK_HZ / 1000) * WD_PERIOD_MS;
  localparam int unsigned CNT_W = 26;
  localparam logic [CNT_W-1:0] CNT_ONE = 26'h1;
  // positions of the pins inside the synchroniser vector
  localparam int unsigned IN_SUP  = 0;
  localparam int unsigned IN_MR   = 1;
  localparam int unsigned IN_KICK = 2;
  localparam int unsigned IN_DIS  = 3;
  localparam int unsigned IN_PF   = 4;
  localparam int unsigned N_IN    = 5;
  // supply low asserted, manual reset high, kick low, watchdog on, sense high
  localparam logic [N_IN-1:0] SYNC_RST = 5'h13;
endpackage

// ### verilog/svrwd_top.sv
// supervisor: reset stretcher, watchdog and power-fail pass-through
// assumes comparators outside give logic-level indications; all inputs except clock and reset asynchronous
`timescale 1ns/1ns
module svrwd_top #(
  parameter int unsigned RST_STRETCH_CYC = svrwd_pkg::RST_STRETCH_CYC,
  parameter int unsigned WD_PERIOD_CYC   = svrwd_pkg::WD_PERIOD_CYC
) (
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  input  wire logic SUPPLY_LOW_IN,
  input  wire logic MANUAL_RESET_N_IN,
  input  wire logic WD_KICK_IN,
  input  wire logic WD_DISABLE_IN,
  input  wire logic PWR_FAIL_SENSE_IN,
  output logic      RESET_N_OUT,
  output logic      RESET_OUT,
  output logic      WD_EXPIRED_N_OUT,
  output logic      PWR_FAIL_WARN_N_OUT
);
  import svrwd_pkg::*;

  // ************************************
  // local types and constants
  // ************************************
  // one-hot codes keep each state one flop, cheap to decode
  typedef enum logic [2:0] {
    SVRWD_HOLD    = 3'h1,
    SVRWD_STRETCH = 3'h2,
    SVRWD_RUN     = 3'h4
  } svrwd_rst_state_t;

  // last count of each timer; timers stop there rather than wrap
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_STRETCH_CYC) - CNT_ONE;
  localparam logic [CNT_W-1:0] WD_LAST  = CNT_W'(WD_PERIOD_CYC) - CNT_ONE;

  // ************************************
  // shared decoding
  // ************************************
  // a timer has finished once it reaches its last value
  function automatic logic cnt_at_end(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last
  );
    cnt_at_end = (cnt >= last);
  endfunction

  // next timer value: clear, saturate at the end, or count up
  // saturating avoids a wrapped count releasing an output by itself
  function automatic logic [CNT_W-1:0] cnt_next(
    input logic             clear,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last
  );
    logic [CNT_W-1:0] step;
    step = cnt + CNT_ONE;
    if (clear) begin
      cnt_next = '0;
    end else if (cnt_at_end(cnt, last)) begin
      cnt_next = cnt;
    end else begin
      cnt_next = step;
    end
  endfunction

  // ************************************
  // input synchronisers
  // ************************************
  // two flops per pin; only the second stage is read anywhere
  wire [N_IN-1:0] raw_in;
  wire [N_IN-1:0] sync_in;

  assign raw_in[IN_SUP]  = SUPPLY_LOW_IN;
  assign raw_in[IN_MR]   = MANUAL_RESET_N_IN;
  assign raw_in[IN_KICK] = WD_KICK_IN;
  assign raw_in[IN_DIS]  = WD_DISABLE_IN;
  assign raw_in[IN_PF]   = PWR_FAIL_SENSE_IN;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      logic stage1_ff;
      logic stage2_ff;

      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          stage1_ff <= SYNC_RST[gi];
          stage2_ff <= SYNC_RST[gi];
        end else begin
          stage1_ff <= raw_in[gi];
          stage2_ff <= stage1_ff;
        end
      end

      assign sync_in[gi] = stage2_ff;
    end
  endgenerate

  // ************************************
  // synchronised input names
  // ************************************
  // supply low resets to asserted, so a full stretch follows every reset
  wire supply_low = sync_in[IN_SUP];
  wire mr_low     = ~sync_in[IN_MR];
  wire kick_s     = sync_in[IN_KICK];
  wire wd_off     = sync_in[IN_DIS];
  wire pf_sense   = sync_in[IN_PF];

  // ************************************
  // kick edge detector
  // ************************************
  // resets to the synchroniser's own level, so no false edge after reset
  logic kick_d_ff;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      kick_d_ff <= SYNC_RST[IN_KICK];
    end else begin
      kick_d_ff <= kick_s;
    end
  end

  // both directions count: a slow toggle is as good as a pulse
  wire kick_edge = kick_s ^ kick_d_ff;

  // ************************************
  // reset stretch timer
  // ************************************
  logic [CNT_W-1:0] rst_cnt_ff;
  svrwd_rst_state_t rst_state_ff;
  svrwd_rst_state_t nxt_rst_state;

  wire             rst_src     = supply_low | mr_low;
  wire             rst_done    = cnt_at_end(rst_cnt_ff, RST_LAST);
  wire [CNT_W-1:0] nxt_rst_cnt = cnt_next(rst_src, rst_cnt_ff, RST_LAST);

  // any source sends the sequencer back to hold, whatever it was doing
  always_comb begin
    nxt_rst_state = SVRWD_HOLD;
    case (rst_state_ff)
      SVRWD_HOLD: begin
        if (rst_src) begin
          nxt_rst_state = SVRWD_HOLD;
        end else if (rst_done) begin
          nxt_rst_state = SVRWD_RUN;
        end else begin
          nxt_rst_state = SVRWD_STRETCH;
        end
      end
      SVRWD_STRETCH: begin
        // a short glitch on a source restarts the whole stretch
        if (rst_src) begin
          nxt_rst_state = SVRWD_HOLD;
        end else if (rst_done) begin
          nxt_rst_state = SVRWD_RUN;
        end else begin
          nxt_rst_state = SVRWD_STRETCH;
        end
      end
      SVRWD_RUN: begin
        if (rst_src) begin
          nxt_rst_state = SVRWD_HOLD;
        end else begin
          nxt_rst_state = SVRWD_RUN;
        end
      end
      default: begin
        nxt_rst_state = SVRWD_HOLD;
      end
    endcase
  end

  // reset is released only from the run state
  wire nxt_reset_n = (nxt_rst_state == SVRWD_RUN);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rst_cnt_ff   <= '0;
      rst_state_ff <= SVRWD_HOLD;
    end else begin
      rst_cnt_ff   <= nxt_rst_cnt;
      rst_state_ff <= nxt_rst_state;
    end
  end

  // ************************************
  // watchdog timer
  // ************************************
  // supply low clears the count, so the period starts fresh on recovery
  logic [CNT_W-1:0] wd_cnt_ff;

  wire             wd_hold          = wd_off | kick_edge | supply_low;
  wire             wd_done          = cnt_at_end(wd_cnt_ff, WD_LAST);
  wire [CNT_W-1:0] nxt_wd_cnt       = cnt_next(wd_hold, wd_cnt_ff, WD_LAST);
  wire             nxt_wd_expired_n = ~supply_low & (wd_off | ~wd_done);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wd_cnt_ff <= '0;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  // ************************************
  // output registers
  // ************************************
  // stretch never looks at the watchdog: a timeout reaches reset only by outside wiring
  // limitation: every output lags its pin by three clocks through the synchroniser
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RESET_N_OUT         <= 1'b0;
      RESET_OUT           <= 1'b1;
      WD_EXPIRED_N_OUT    <= 1'b1;
      PWR_FAIL_WARN_N_OUT <= 1'b1;
    end else begin
      RESET_N_OUT         <= nxt_reset_n;
      RESET_OUT           <= ~nxt_reset_n;
      WD_EXPIRED_N_OUT    <= nxt_wd_expired_n;
      PWR_FAIL_WARN_N_OUT <= pf_sense;
    end
  end
endmodule

// ### test/svrwd_kick_model.sv
// processor model driving the kick line; off-edge, 400 ns levels
`timescale 1ns/1ns
module svrwd_kick_model (
  input  wire logic run_in,
  output logic      kick_out
);
  initial begin
    kick_out = 1'h0;
    forever #400 if (run_in) kick_out = ~kick_out;
  end
endmodule

// ### test/svrwd_checker.sv
// supervisor port assertions; assumes sim counts 20 and 50
`timescale 1ns/1ns
module svrwd_checker (input wire logic CLK_IN, RST_IN, SUPPLY_LOW_IN, MANUAL_RESET_N_IN, WD_KICK_IN, WD_DISABLE_IN,
  PWR_FAIL_SENSE_IN, RESET_N_OUT, RESET_OUT, WD_EXPIRED_N_OUT, PWR_FAIL_WARN_N_OUT);
  logic [7:0] q_ff;
  logic       k_ff;
  always_ff @(posedge CLK_IN) k_ff <= WD_KICK_IN;
  always_ff @(posedge CLK_IN) q_ff <= (RST_IN | SUPPLY_LOW_IN | WD_DISABLE_IN | WD_KICK_IN ^ k_ff) ? 8'h00 :
    (q_ff == 8'hff) ? q_ff : q_ff + 8'h01;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_sup; SUPPLY_LOW_IN [*4]; endsequence
  a_rst_pair: assert property (RESET_OUT != RESET_N_OUT) else $error("pair");
  a_mr_low: assert property (!MANUAL_RESET_N_IN [*3] |-> ##[0:3] !RESET_N_OUT) else $error("mr");
  a_sup_low: assert property (s_sup |-> !RESET_N_OUT && !WD_EXPIRED_N_OUT) else $error("sup");
  a_rst_hold: assert property ($rose(RESET_N_OUT) |-> $past(MANUAL_RESET_N_IN, 16) && !$past(SUPPLY_LOW_IN, 16)) else $error("h");
  a_wd_off: assert property ((WD_DISABLE_IN & !SUPPLY_LOW_IN) [*5] |-> WD_EXPIRED_N_OUT) else $error("off");
  a_wd_expire: assert property (q_ff == 8'h3c |-> !WD_EXPIRED_N_OUT) else $error("exp");
  a_wd_kick: assert property (q_ff inside {[8'h08:8'h28]} |-> WD_EXPIRED_N_OUT) else $error("kick");
  a_pf_follow: assert property ($stable(PWR_FAIL_SENSE_IN) [*4] |-> PWR_FAIL_WARN_N_OUT == PWR_FAIL_SENSE_IN) else $error("pf");
endmodule
bind svrwd_top svrwd_checker u_chk (.*);

// ### test/svrwd_top_bench.sv
// supervisor bench; short counts, pull-up on manual reset modelled as 1
`timescale 1ns/1ns
module svrwd_top_bench;
  logic c = 0, r = 1, s = 0, m = 1, d = 0, p = 1, g = 0, e, v, qe[$];
  wire  k, rn, ro, wd, pf;
  int   n_fail = 0, num_checks = 0, n = 0, t, qt[$];
  always #20 c = ~c;
  svrwd_kick_model pm (.run_in(g), .kick_out(k));
  svrwd_top #(.RST_STRETCH_CYC(20), .WD_PERIOD_CYC(50)) dut (.CLK_IN(c), .RST_IN(r), .SUPPLY_LOW_IN(s),
    .MANUAL_RESET_N_IN(m), .WD_KICK_IN(k), .WD_DISABLE_IN(d), .PWR_FAIL_SENSE_IN(p), .RESET_N_OUT(rn),
    .RESET_OUT(ro), .WD_EXPIRED_N_OUT(wd), .PWR_FAIL_WARN_N_OUT(pf));
  task w(int i); repeat (i) @(posedge c); endtask
  task ck(int i, logic x); qt.push_back(i); qe.push_back(x); endtask
  task final_report;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge c) while (qt.size() > 0) begin
    t = qt.pop_front(); e = qe.pop_front(); v = t == 0 ? rn : t == 1 ? wd : t == 2 ? pf : ro; num_checks++;
    if (v !== e) begin n_fail++; $display("[ERR] out%0d exp %b saw %b", t, e, v); end
  end
  always @(posedge c) if (++n == 2000) begin n_fail++; final_report; end
  initial begin
    void'($urandom(7122));
    w(12); r <= 0; w(30); ck(0, 1); ck(3, 0);
    m <= 0; w(5 + $urandom % 8); ck(0, 0); ck(3, 1);
    m <= 1; w(10); ck(0, 0); w(20); ck(0, 1);
    repeat (4) begin p <= 1'($urandom % 2); w(5); ck(2, p); end
    g <= 1; w(200); ck(1, 1); g <= 0; w(110); ck(1, 0); ck(0, 1);
    d <= 1; w(8); ck(1, 1); d <= 0; s <= 1; w(6); ck(0, 0); ck(1, 0);
    s <= 0; w(10); ck(0, 0); w(20); ck(0, 1); w(1); final_report;
  end
endmodule
